// ==== core/host_port_pkg.sv ====
/*
 * Constants and types shared by the quad UART host bus port.
 * Assumes a single system clock with every pin input resynchronised.
 */
package host_port_pkg;
    localparam int DATA_W = 8;
    localparam int IDX_W = 3;
    localparam int CHAN_W = 2;
    localparam int NUM_CHAN = 4;
    localparam int SYNC_STAGES = 2;
    // Reset values
    localparam logic [7:0] DATA_RESET = 8'h00;
    localparam logic [2:0] IDX_RESET = 3'h0;
    localparam logic [1:0] CHAN_RESET = 2'h0;
    localparam logic [3:0] SEL_IDLE = 4'hF;
    // Channel select bit positions in the low-strap style
    localparam int CS_DEVICE_BIT = 0;
    localparam int CS_CHAN_LOW_BIT = 1;
    localparam int CS_CHAN_HIGH_BIT = 2;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_FETCH,
        ST_READ,
        ST_WRITE
    } access_state_t;
endpackage

// ==== core/pin_sample_if.sv ====
/*
 * Synchronised host pin levels passed from the sampler to the port logic.
 * Assumes both ends share the system clock.
 */
`timescale 1ns/1ps
interface pin_sample_if;
    import host_port_pkg::*;
    logic [DATA_W-1:0] data;
    logic read_strobe_n;
    logic write_strobe_n;
    logic [NUM_CHAN-1:0] select_n;
    logic [IDX_W-1:0] index;
    logic bus_style;

    modport producer (
        output data, read_strobe_n, write_strobe_n, select_n, index, bus_style
    );
    modport consumer (
        input data, read_strobe_n, write_strobe_n, select_n, index, bus_style
    );
endinterface

// ==== core/pin_sampler.sv ====
/*
 * Two flip-flop resynchroniser for every host bus pin input.
 * Assumes pins are asynchronous to clk_sys_i; first stage feeds only the second.
 */
`timescale 1ns/1ps
module pin_sampler
    import host_port_pkg::*;
(
    // Clock and control
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Raw pins
    input wire logic [DATA_W-1:0] data_in_i,
    input wire logic host_read_strobe_n_i,
    input wire logic host_write_strobe_n_i,
    input wire logic [NUM_CHAN-1:0] select_n_i,
    input wire logic [IDX_W-1:0] register_index_i,
    input wire logic bus_style_i,
    // Synchronised levels
    pin_sample_if.producer smp
);
    localparam int W = DATA_W + NUM_CHAN + IDX_W + 3;
    localparam logic [W-1:0] IDLE_VEC = {DATA_RESET, 1'b1, 1'b1, SEL_IDLE, IDX_RESET, 1'b1};

    logic [W-1:0] stage [SYNC_STAGES];
    logic [W-1:0] raw;

    assign raw = {data_in_i, host_read_strobe_n_i, host_write_strobe_n_i,
                  select_n_i, register_index_i, bus_style_i};

    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            for (int i = 0; i < SYNC_STAGES; i++) begin
                stage[i] <= IDLE_VEC;
            end
        end else if (ce_i) begin
            stage[0] <= raw;
            for (int i = 1; i < SYNC_STAGES; i++) begin
                stage[i] <= stage[i-1];
            end
        end
    end

    assign {smp.data, smp.read_strobe_n, smp.write_strobe_n,
            smp.select_n, smp.index, smp.bus_style} = stage[SYNC_STAGES-1];
endmodule

// ==== core/quad_uart_host_bus_port.sv ====
/*
 * Host parallel bus port of a four channel UART: strobe or select/direction
 * bus style, chosen by a strap, turned into register read and write requests.
 * Assumes the channel register file answers rdata_i combinationally from
 * reg_channel_o and reg_index_o, and that ce_i stays high for the assertions.
 */
`timescale 1ns/1ps
module quad_uart_host_bus_port
    import host_port_pkg::*;
(
    // Clock and control
    input wire logic clk_sys_i,
    input wire logic reset_i,
    input wire logic ce_i,
    // Host pins
    input wire logic [DATA_W-1:0] data_in_i,
    output logic [DATA_W-1:0] data_out_o,
    output logic data_oe_o,
    input wire logic host_read_strobe_n_i,
    input wire logic host_write_strobe_n_i,
    input wire logic first_channel_select_n_i,
    input wire logic second_channel_select_n_i,
    input wire logic third_channel_select_n_i,
    input wire logic fourth_channel_select_n_i,
    input wire logic [IDX_W-1:0] register_index_i,
    input wire logic bus_style_i,
    // Channel register side
    output logic reg_read_o,
    output logic reg_write_o,
    output logic [CHAN_W-1:0] reg_channel_o,
    output logic [IDX_W-1:0] reg_index_o,
    output logic [DATA_W-1:0] reg_wdata_o,
    input wire logic [DATA_W-1:0] rdata_i
);
    pin_sample_if smp ();

    pin_sampler u_sampler (
        .clk_sys_i(clk_sys_i),
        .reset_i(reset_i),
        .ce_i(ce_i),
        .data_in_i(data_in_i),
        .host_read_strobe_n_i(host_read_strobe_n_i),
        .host_write_strobe_n_i(host_write_strobe_n_i),
        .select_n_i({fourth_channel_select_n_i, third_channel_select_n_i,
                     second_channel_select_n_i, first_channel_select_n_i}),
        .register_index_i(register_index_i),
        .bus_style_i(bus_style_i),
        .smp(smp)
    );

    access_state_t state;
    logic any_sel;
    logic [CHAN_W-1:0] sel_chan;
    logic rd_req;
    logic wr_req;
    logic req_live;
    logic [DATA_W-1:0] held_data;

    // Channel decode per bus style
    always_comb begin
        any_sel = 1'b0;
        sel_chan = CHAN_RESET;
        if (smp.bus_style) begin
            // Lowest select wins if several are low
            for (int i = NUM_CHAN - 1; i >= 0; i--) begin
                if (!smp.select_n[i]) begin
                    any_sel = 1'b1;
                    sel_chan = CHAN_W'(i);
                end
            end
        end else begin
            any_sel = !smp.select_n[CS_DEVICE_BIT];
            sel_chan = {smp.select_n[CS_CHAN_HIGH_BIT],
                        smp.select_n[CS_CHAN_LOW_BIT]};
        end
    end

    // Access requests per bus style
    always_comb begin
        if (smp.bus_style) begin
            rd_req = any_sel && !smp.read_strobe_n;
            wr_req = any_sel && !smp.write_strobe_n && smp.read_strobe_n;
        end else begin
            rd_req = any_sel && smp.write_strobe_n;
            wr_req = any_sel && !smp.write_strobe_n;
        end
    end

    assign req_live = (state == ST_WRITE) ? wr_req : rd_req;

    // Transaction sequencing
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            state <= ST_IDLE;
        end else if (ce_i) begin
            case (state)
                ST_IDLE: begin
                    if (rd_req) begin
                        state <= ST_FETCH;
                    end else if (wr_req) begin
                        state <= ST_WRITE;
                    end
                end
                ST_FETCH: begin
                    state <= req_live ? ST_READ : ST_IDLE;
                end
                ST_READ: begin
                    if (!req_live) begin
                        state <= ST_IDLE;
                    end
                end
                ST_WRITE: begin
                    if (!req_live) begin
                        state <= ST_IDLE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // Address capture at the start of a transaction
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_channel_o <= CHAN_RESET;
            reg_index_o <= IDX_RESET;
        end else if (ce_i && state == ST_IDLE && (rd_req || wr_req)) begin
            reg_channel_o <= sel_chan;
            reg_index_o <= smp.index;
        end
    end

    // Read request pulse and bus drive
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            reg_read_o <= 1'b0;
            data_out_o <= DATA_RESET;
            data_oe_o <= 1'b0;
        end else if (ce_i) begin
            reg_read_o <= (state == ST_IDLE) && rd_req;
            if (state == ST_FETCH && req_live) begin
                data_out_o <= rdata_i;
                data_oe_o <= 1'b1;
            end else if (state != ST_READ || !req_live) begin
                data_oe_o <= 1'b0;
            end
        end
    end

    // Write data follows the bus while the strobe is low
    always_ff @(posedge clk_sys_i) begin
        if (reset_i) begin
            held_data <= DATA_RESET;
            reg_write_o <= 1'b0;
            reg_wdata_o <= DATA_RESET;
        end else if (ce_i) begin
            reg_write_o <= 1'b0;
            if ((state == ST_IDLE || state == ST_WRITE) && wr_req) begin
                held_data <= smp.data;
            end
            if (state == ST_WRITE && !req_live) begin
                reg_write_o <= 1'b1;
                reg_wdata_o <= held_data;
            end
        end
    end

    default clocking cb @(posedge clk_sys_i); endclocking
    default disable iff (reset_i || !ce_i);

    property p_drive_only_reads;
        $rose(data_oe_o) |-> $past(reg_read_o) && !reg_write_o;
    endproperty
    a_drive_only_reads: assert property (p_drive_only_reads)
        else $error("data bus driven outside a read");

    property p_read_data;
        $rose(data_oe_o) |-> data_out_o == $past(rdata_i);
    endproperty
    a_read_data: assert property (p_read_data)
        else $error("driven byte differs from addressed register");

    property p_strobe_read;
        state == ST_IDLE && smp.bus_style && !smp.read_strobe_n
            && smp.select_n == 4'hE |=> reg_read_o && reg_channel_o == 2'h0;
    endproperty
    a_strobe_read: assert property (p_strobe_read)
        else $error("read strobe did not start a read");

    property p_write_commit;
        reg_write_o |-> reg_wdata_o == $past(smp.data, 2) && $past(state == ST_WRITE);
    endproperty
    a_write_commit: assert property (p_write_commit)
        else $error("write committed wrong byte");

    property p_dir_write;
        state == ST_IDLE && !smp.bus_style && !smp.select_n[0] && !smp.write_strobe_n
            |=> !reg_read_o ##1 !data_oe_o;
    endproperty
    a_dir_write: assert property (p_dir_write)
        else $error("direction low treated as read");

    property p_unselected;
        state == ST_IDLE && smp.bus_style && smp.select_n == 4'hF |=> !reg_read_o;
    endproperty
    a_unselected: assert property (p_unselected)
        else $error("access without a channel select");

    property p_dir_qualify;
        state == ST_IDLE && !smp.bus_style && smp.select_n[0] |=> !reg_read_o;
    endproperty
    a_dir_qualify: assert property (p_dir_qualify)
        else $error("access without device select");

    property p_dir_channel;
        state == ST_IDLE && !smp.bus_style && !smp.select_n[0] && smp.write_strobe_n
            |=> reg_read_o && reg_channel_o == $past(smp.select_n[2:1]);
    endproperty
    a_dir_channel: assert property (p_dir_channel)
        else $error("channel bits decoded wrongly");

    property p_index;
        reg_read_o |-> reg_index_o == $past(smp.index);
    endproperty
    a_index: assert property (p_index)
        else $error("register index not captured");

    c_strobe_read: cover property (smp.bus_style && reg_read_o ##[1:20] $fell(data_oe_o));
    c_strobe_write: cover property (smp.bus_style && reg_write_o);
    c_dir_read: cover property (!smp.bus_style && $rose(data_oe_o));
    c_dir_write: cover property (!smp.bus_style && reg_write_o && reg_channel_o == 2'h3);
endmodule

// ==== verification/host_bus_model.sv ====
/*
 * Host processor model for the quad UART host bus port.
 * Assumes pins change 1 ns after a clock edge and the port's data enable is high while it drives.
 */
`timescale 1ns/1ps
module host_bus_model
    import host_port_pkg::*;
(
    // Clock
    input wire logic clk_sys_i,
    // Port side of the data bus
    input wire logic [DATA_W-1:0] data_out_i,
    input wire logic data_oe_i,
    // Host pins
    output logic [DATA_W-1:0] data_bus_o,
    output logic host_read_strobe_n_o,
    output logic host_write_strobe_n_o,
    output logic [NUM_CHAN-1:0] select_n_o,
    output logic [IDX_W-1:0] register_index_o,
    output logic bus_style_o
);
    logic [DATA_W-1:0] host_data = 8'h00;
    logic host_oe = 1'b0;
    logic [DATA_W-1:0] last_level = 8'h00;

    // Wire level; a released bus shows the inverse of the last driven byte
    assign data_bus_o = data_oe_i ? data_out_i : (host_oe ? host_data : ~last_level);
    always @(posedge clk_sys_i) begin
        if (data_oe_i === 1'b1 || host_oe) begin
            last_level <= data_bus_o;
        end
    end

    initial begin
        host_read_strobe_n_o = 1'b1;
        host_write_strobe_n_o = 1'b1;
        select_n_o = 4'hF;
        register_index_o = 3'h0;
        bus_style_o = 1'b1;
    end

    // Strap changes only while idle
    task automatic set_style(input logic s);
        @(posedge clk_sys_i);
        #1;
        bus_style_o = s;
        repeat (3) @(posedge clk_sys_i);
    endtask

    task automatic access(input logic wr, input logic en, input logic [1:0] ch,
                          input logic [2:0] idx, input logic [7:0] wd, output logic [7:0] rd);
        @(posedge clk_sys_i);
        #1;
        register_index_o = idx;
        host_data = wd;
        host_oe = wr;
        if (bus_style_o) begin
            select_n_o = en ? ~(4'h1 << ch) : 4'hF;
            if (wr) host_write_strobe_n_o = 1'b0;
            else host_read_strobe_n_o = 1'b0;
        end else begin
            host_write_strobe_n_o = ~wr;
            select_n_o = {1'b1, ch[1], ch[0], ~en};
        end
        repeat (8) @(posedge clk_sys_i);
        rd = data_bus_o;
        #1;
        if (bus_style_o) begin
            host_read_strobe_n_o = 1'b1;
            host_write_strobe_n_o = 1'b1;
            select_n_o = 4'hF;
        end else begin
            select_n_o[0] = 1'b1;
        end
        @(posedge clk_sys_i);
        #1;
        host_oe = 1'b0;
        host_write_strobe_n_o = 1'b1;
        select_n_o = 4'hF;
        repeat (3) @(posedge clk_sys_i);
        #1;
    endtask
endmodule

// ==== verification/testbench.sv ====
/*
 * Self-checking bench for the quad UART host bus port.
 * Assumes the host model drives the pins and a register file answers combinationally.
 */
`timescale 1ns/1ps
module testbench;
    import host_port_pkg::*;
    logic clk_sys_i = 1'b0;
    logic reset_i = 1'b1;
    logic [7:0] data_bus, data_out, rdata, wdata;
    logic data_oe_o, rd_n, wr_n, style, reg_read, reg_write;
    logic [3:0] sel_n;
    logic [2:0] idx_pin, reg_idx, last_idx;
    logic [1:0] reg_chan, last_chan;
    logic [7:0] last_wdata;
    int error_cnt = 0;
    int comparisons = 0;
    int rd_cnt = 0;
    int wr_cnt = 0;

    initial begin
        forever #25 clk_sys_i = ~clk_sys_i;
    end

    quad_uart_host_bus_port u_quad_uart_host_bus_port (
        .clk_sys_i(clk_sys_i), .reset_i(reset_i), .ce_i(1'b1),
        .data_in_i(data_bus), .data_out_o(data_out), .data_oe_o(data_oe_o),
        .host_read_strobe_n_i(rd_n), .host_write_strobe_n_i(wr_n),
        .first_channel_select_n_i(sel_n[0]), .second_channel_select_n_i(sel_n[1]),
        .third_channel_select_n_i(sel_n[2]), .fourth_channel_select_n_i(sel_n[3]),
        .register_index_i(idx_pin), .bus_style_i(style),
        .reg_read_o(reg_read), .reg_write_o(reg_write), .reg_channel_o(reg_chan),
        .reg_index_o(reg_idx), .reg_wdata_o(wdata), .rdata_i(rdata)
    );

    host_bus_model u_host_bus_model (
        .clk_sys_i(clk_sys_i), .data_out_i(data_out), .data_oe_i(data_oe_o),
        .data_bus_o(data_bus), .host_read_strobe_n_o(rd_n), .host_write_strobe_n_o(wr_n),
        .select_n_o(sel_n), .register_index_o(idx_pin), .bus_style_o(style)
    );

    // Register file answer encodes channel and index
    assign rdata = {1'b1, reg_chan, reg_idx, 2'h1};

    always @(posedge clk_sys_i) begin
        if (reg_read === 1'b1) rd_cnt++;
        if (reg_write === 1'b1) wr_cnt++;
        if ((reg_read | reg_write) === 1'b1) begin
            last_chan = reg_chan;
            last_idx = reg_idx;
            last_wdata = wdata;
        end
    end

    task automatic report_and_stop();
        $display("Counts: %0d comparisons, %0d errors", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic xfer(input logic wr, input logic en, input logic [1:0] ch,
                        input logic [2:0] idx, input logic [7:0] wd);
        int r0;
        int w0;
        logic [7:0] rd;
        r0 = rd_cnt;
        w0 = wr_cnt;
        u_host_bus_model.access(wr, en, ch, idx, wd, rd);
        chk(8'(rd_cnt - r0), {7'h00, en & ~wr});
        chk(8'(wr_cnt - w0), {7'h00, en & wr});
        if (en) chk({6'h00, last_chan}, {6'h00, ch});
        if (en) chk({5'h00, last_idx}, {5'h00, idx});
        if (en & ~wr) chk(rd, {1'b1, ch, idx, 2'h1});
        if (en & wr) chk(last_wdata, wd);
        chk({7'h00, data_oe_o}, 8'h00);
    endtask

    task automatic strobe_reads();
        u_host_bus_model.set_style(1'b1);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 1'b1, i[1:0], i[2:0], 8'h00);
        end
    endtask

    task automatic strobe_writes();
        for (int i = 0; i < 8; i++) begin
            xfer(1'b1, 1'b1, i[1:0], 3'(7 - i), 8'hA5 ^ 8'(i));
        end
    endtask

    task automatic strobe_unselected();
        xfer(1'b0, 1'b0, 2'h2, 3'h5, 8'h00);
        xfer(1'b1, 1'b0, 2'h1, 3'h3, 8'h3C);
    endtask

    task automatic direction_access();
        u_host_bus_model.set_style(1'b0);
        for (int i = 0; i < 8; i++) begin
            xfer(1'b0, 1'b1, i[1:0], 3'(i + 3), 8'h00);
            xfer(1'b1, 1'b1, i[1:0], i[2:0], 8'h0F ^ 8'(i * 17));
        end
    endtask

    task automatic direction_unselected();
        xfer(1'b0, 1'b0, 2'h3, 3'h1, 8'h00);
        xfer(1'b1, 1'b0, 2'h0, 3'h6, 8'hC3);
    endtask

    initial begin
        repeat (20000) @(posedge clk_sys_i);
        error_cnt++;
        report_and_stop();
    end

    initial begin
        repeat (8) @(posedge clk_sys_i);
        #1;
        reset_i = 1'b0;
        strobe_reads();
        strobe_writes();
        strobe_unselected();
        direction_access();
        direction_unselected();
        report_and_stop();
    end
endmodule
